// ==== verilog/spc_pin_control.sv ====
/*
  SDRAM pin control: turns controller commands into registered SDRAM
  control pins, data masks, address bit ten and clock enable, and hands
  the bus to a host with the SDRAM parked in self-refresh.
  Assumes all inputs are synchronous to clk and held stable while valid.
*/
`include "spc_cfg.svh"

module spc_pin_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire spc_pkg::spc_cmd_t cmdKind,
  input wire logic [`SPC_ADDR_W-1:0] cmdAddr,
  input wire logic cmdA10,
  input wire logic cmdSingleWord,
  input wire logic bus32Mode,
  input wire logic busOwner,
  input wire logic hostBusRequestN,
  output logic sdramSpaceSelectN,
  output logic sdramSpaceSelectOe,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic sdramWriteEnableN,
  output logic lowWordDataMask,
  output logic highWordDataMask,
  output logic sdramAddrBitTen,
  output logic sdramClockEnable,
  output logic sdramCtrlOe,
  output logic hostBusGrantN,
  output logic hostBusGrantOe
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic hostReq;
  logic cmdTake;
  logic [`SPC_SPACE_HI-`SPC_SPACE_LO:0] upperAddressBits;
  logic inWindow;
  logic addrFree;
  logic issue;
  logic wordOdd;
  spc_pkg::spc_cmd_t effCmd;
  spc_pkg::spc_arb_state_t arbState;
  spc_pkg::spc_arb_state_t arbNext;
  logic [2:0] pinCode;
  logic ckeTouch;
  logic ckeValue;

  logic ready_reg, ready_next;
  logic sel_reg, sel_next;
  logic selOe_reg, selOe_next;
  logic row_reg, row_next;
  logic col_reg, col_next;
  logic we_reg, we_next;
  logic lowMask_reg, lowMask_next;
  logic highMask_reg, highMask_next;
  logic a10_reg, a10_next;
  logic cke_reg, cke_next;
  logic ctrlOe_reg, ctrlOe_next;
  logic grant_reg, grant_next;
  logic grantOe_reg, grantOe_next;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  assign hostReq = !hostBusRequestN;
  assign cmdTake = cmdValid && ready_reg;
  assign upperAddressBits = cmdAddr[`SPC_SPACE_HI:`SPC_SPACE_LO];
  assign inWindow = (upperAddressBits == `SPC_SDRAM_SPACE);
  assign wordOdd = cmdAddr[`SPC_WORD_ODD_BIT];

  // Refresh and clock enable commands need no address lines, so they
  // may run while another transfer owns the shared address bus
  always_comb begin
    case (cmdKind)
      spc_pkg::SPC_CMD_REFRESH,
      spc_pkg::SPC_CMD_SELF_ENTER,
      spc_pkg::SPC_CMD_SELF_EXIT,
      spc_pkg::SPC_CMD_SUSPEND_ENTER,
      spc_pkg::SPC_CMD_SUSPEND_EXIT: addrFree = 1'h1;
      default: addrFree = 1'h0;
    endcase
  end

  assign issue = cmdTake && (inWindow || addrFree);

  // ----------------------------------------
  // Command selection
  // ----------------------------------------
  always_comb begin
    effCmd = spc_pkg::SPC_CMD_NOP;
    case (arbState)
      spc_pkg::SPC_ARB_SELF: effCmd = spc_pkg::SPC_CMD_SELF_ENTER;
      spc_pkg::SPC_ARB_WAKE: effCmd = spc_pkg::SPC_CMD_SELF_EXIT;
      spc_pkg::SPC_ARB_IDLE: begin
        if (issue) begin
          effCmd = cmdKind;
        end
      end
      default: effCmd = spc_pkg::SPC_CMD_NOP;
    endcase
  end

  spc_cmd_encode u_encode (
    .cmd(effCmd),
    .pinCode(pinCode),
    .ckeTouch(ckeTouch),
    .ckeValue(ckeValue)
  );

  spc_host_arb u_arb (
    .clk(clk),
    .rst_n(rst_n),
    .hostReq(hostReq),
    .busOwner(busOwner),
    .cmdTake(cmdTake),
    .state(arbState),
    .stateNext(arbNext)
  );

  // ----------------------------------------
  // Pin next values
  // ----------------------------------------
  always_comb begin
    ready_next = (arbNext == spc_pkg::SPC_ARB_IDLE) && !hostReq && busOwner;
    sel_next = !(issue || arbState == spc_pkg::SPC_ARB_SELF
                 || arbState == spc_pkg::SPC_ARB_WAKE);
    row_next = pinCode[2];
    col_next = pinCode[1];
    we_next = pinCode[0];
    // Masks exist only beside a write; reads and other commands leave them off
    lowMask_next = 1'h0;
    highMask_next = 1'h0;
    if (effCmd == spc_pkg::SPC_CMD_WRITE) begin
      lowMask_next = !bus32Mode && cmdSingleWord && wordOdd;
      highMask_next = bus32Mode || (cmdSingleWord && !wordOdd);
    end
    a10_next = issue ? cmdA10 : a10_reg;
    cke_next = ckeTouch ? ckeValue : cke_reg;
    // Pins float from the float state until the wake state hands them back
    ctrlOe_next = busOwner && (arbState == spc_pkg::SPC_ARB_IDLE
                  || arbState == spc_pkg::SPC_ARB_SELF
                  || arbState == spc_pkg::SPC_ARB_WAKE);
    selOe_next = ctrlOe_next;
    grant_next = !(arbState == spc_pkg::SPC_ARB_GRANT && hostReq);
    grantOe_next = busOwner;
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_reg <= `SPC_RST_READY;
      sel_reg <= `SPC_RST_STROBE;
      selOe_reg <= `SPC_RST_OE;
      row_reg <= `SPC_RST_STROBE;
      col_reg <= `SPC_RST_STROBE;
      we_reg <= `SPC_RST_STROBE;
      lowMask_reg <= `SPC_RST_MASK;
      highMask_reg <= `SPC_RST_MASK;
      a10_reg <= `SPC_RST_A10;
      cke_reg <= `SPC_RST_CKE;
      ctrlOe_reg <= `SPC_RST_OE;
      grant_reg <= `SPC_RST_GRANT_N;
      grantOe_reg <= `SPC_RST_OE;
    end else begin
      ready_reg <= ready_next;
      sel_reg <= sel_next;
      selOe_reg <= selOe_next;
      row_reg <= row_next;
      col_reg <= col_next;
      we_reg <= we_next;
      lowMask_reg <= lowMask_next;
      highMask_reg <= highMask_next;
      a10_reg <= a10_next;
      cke_reg <= cke_next;
      ctrlOe_reg <= ctrlOe_next;
      grant_reg <= grant_next;
      grantOe_reg <= grantOe_next;
    end
  end

  assign cmdReady = ready_reg;
  assign sdramSpaceSelectN = sel_reg;
  assign sdramSpaceSelectOe = selOe_reg;
  assign rowStrobeN = row_reg;
  assign colStrobeN = col_reg;
  assign sdramWriteEnableN = we_reg;
  assign lowWordDataMask = lowMask_reg;
  assign highWordDataMask = highMask_reg;
  assign sdramAddrBitTen = a10_reg;
  assign sdramClockEnable = cke_reg;
  assign sdramCtrlOe = ctrlOe_reg;
  assign hostBusGrantN = grant_reg;
  assign hostBusGrantOe = grantOe_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_select_window;
    @(posedge clk) disable iff (!rst_n)
    cmdTake && inWindow |=> !sdramSpaceSelectN;
  endproperty
  a_select_window: assert property (p_select_window)
    else $error("select not asserted for window access");

  property p_select_owner;
    @(posedge clk) disable iff (!rst_n)
    !busOwner |=> !sdramSpaceSelectOe && !sdramCtrlOe;
  endproperty
  a_select_owner: assert property (p_select_owner)
    else $error("non owner drives select");

  property p_row_strobe;
    @(posedge clk) disable iff (!rst_n)
    issue && cmdKind == spc_pkg::SPC_CMD_ACTIVATE |=> !rowStrobeN && colStrobeN;
  endproperty
  a_row_strobe: assert property (p_row_strobe)
    else $error("row strobe wrong on activate");

  property p_col_strobe;
    @(posedge clk) disable iff (!rst_n)
    issue && (cmdKind == spc_pkg::SPC_CMD_READ || cmdKind == spc_pkg::SPC_CMD_WRITE)
      |=> !colStrobeN && rowStrobeN;
  endproperty
  a_col_strobe: assert property (p_col_strobe)
    else $error("column strobe wrong on access");

  property p_write_enable;
    @(posedge clk) disable iff (!rst_n)
    issue && cmdKind == spc_pkg::SPC_CMD_READ ##1 !colStrobeN |-> sdramWriteEnableN;
  endproperty
  a_write_enable: assert property (p_write_enable)
    else $error("write enable low on read");

  property p_refresh_code;
    @(posedge clk) disable iff (!rst_n)
    issue && cmdKind == spc_pkg::SPC_CMD_REFRESH
      |=> {rowStrobeN, colStrobeN, sdramWriteEnableN} == `SPC_ENC_REFRESH;
  endproperty
  a_refresh_code: assert property (p_refresh_code)
    else $error("refresh encoding wrong");

  property p_low_mask;
    @(posedge clk) disable iff (!rst_n)
    colStrobeN || sdramWriteEnableN |-> !lowWordDataMask;
  endproperty
  a_low_mask: assert property (p_low_mask)
    else $error("low mask outside a write");

  property p_high_mask;
    @(posedge clk) disable iff (!rst_n)
    issue && cmdKind == spc_pkg::SPC_CMD_WRITE && bus32Mode |=> highWordDataMask;
  endproperty
  a_high_mask: assert property (p_high_mask)
    else $error("high mask off on 32-bit write");

  property p_a10;
    @(posedge clk) disable iff (!rst_n)
    issue |=> sdramAddrBitTen == $past(cmdA10);
  endproperty
  a_a10: assert property (p_a10)
    else $error("address bit ten not driven");

  property p_grant_safe;
    @(posedge clk) disable iff (!rst_n)
    !hostBusGrantN |-> !sdramCtrlOe && !sdramSpaceSelectOe && !sdramClockEnable;
  endproperty
  a_grant_safe: assert property (p_grant_safe)
    else $error("grant with pins driven or SDRAM awake");

  property p_grant_hold;
    @(posedge clk) disable iff (!rst_n)
    !hostBusGrantN && hostReq |=> !hostBusGrantN;
  endproperty
  a_grant_hold: assert property (p_grant_hold)
    else $error("grant dropped while host requests");

  property p_handover;
    @(posedge clk) disable iff (!rst_n)
    arbState == spc_pkg::SPC_ARB_IDLE && hostReq && busOwner && !cmdTake
      |=> ##1 !sdramClockEnable ##2 !hostBusGrantN || !hostReq;
  endproperty
  a_handover: assert property (p_handover)
    else $error("handover sequence late");

endmodule

// ==== include/spc_cfg.svh ====
/*
  Constants of the SDRAM pin control block: address window, command
  encodings, address bit positions and reset values of the pins.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------
// Address window
// ----------------------------------------
`define SPC_ADDR_W 32
`define SPC_SPACE_HI 31
`define SPC_SPACE_LO 26
`define SPC_SDRAM_SPACE 6'h01
`define SPC_WORD_ODD_BIT 0

// ----------------------------------------
// Command encodings {row, column, write enable}, active low
// ----------------------------------------
`define SPC_ENC_MODE 3'h0
`define SPC_ENC_REFRESH 3'h1
`define SPC_ENC_PRECHARGE 3'h2
`define SPC_ENC_ACTIVATE 3'h3
`define SPC_ENC_WRITE 3'h4
`define SPC_ENC_READ 3'h5
`define SPC_ENC_BURST_STOP 3'h6
`define SPC_ENC_NOP 3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPC_RST_STROBE 1'h1
`define SPC_RST_MASK 1'h0
`define SPC_RST_A10 1'h0
`define SPC_RST_CKE 1'h1
`define SPC_RST_OE 1'h0
`define SPC_RST_GRANT_N 1'h1
`define SPC_RST_READY 1'h0

`endif

// ==== include/spc_pkg.sv ====
/*
  Types of the SDRAM pin control block: command kinds and the states of
  the host handover sequence.
  Assumes spc_cfg.svh is available on the include path.
*/
package spc_pkg;

  // ----------------------------------------
  // Commands presented by the controller core
  // ----------------------------------------
  typedef enum logic [3:0] {
    SPC_CMD_NOP = 4'h0,
    SPC_CMD_ACTIVATE = 4'h1,
    SPC_CMD_READ = 4'h2,
    SPC_CMD_WRITE = 4'h3,
    SPC_CMD_PRECHARGE = 4'h4,
    SPC_CMD_REFRESH = 4'h5,
    SPC_CMD_MODE_SET = 4'h6,
    SPC_CMD_BURST_STOP = 4'h7,
    SPC_CMD_SELF_ENTER = 4'h8,
    SPC_CMD_SELF_EXIT = 4'h9,
    SPC_CMD_SUSPEND_ENTER = 4'hA,
    SPC_CMD_SUSPEND_EXIT = 4'hB
  } spc_cmd_t;

  // ----------------------------------------
  // Host handover states, Gray coded from idle through wake (wake to idle flips two bits)
  // ----------------------------------------
  typedef enum logic [2:0] {
    SPC_ARB_IDLE = 3'h0,
    SPC_ARB_SELF = 3'h1,
    SPC_ARB_FLOAT = 3'h3,
    SPC_ARB_GRANT = 3'h2,
    SPC_ARB_WAKE = 3'h6
  } spc_arb_state_t;

endpackage

// ==== verilog/spc_cmd_encode.sv ====
/*
  Command table: maps a command kind onto row strobe, column strobe and
  write enable, plus the clock enable action.
  Assumes a purely combinational use by the pin control block.
*/
`include "spc_cfg.svh"

module spc_cmd_encode (
  input wire spc_pkg::spc_cmd_t cmd,
  output logic [2:0] pinCode,
  output logic ckeTouch,
  output logic ckeValue
);

  // ----------------------------------------
  // Encoding
  // ----------------------------------------
  always_comb begin
    pinCode = `SPC_ENC_NOP;
    ckeTouch = 1'h0;
    ckeValue = 1'h1;
    case (cmd)
      spc_pkg::SPC_CMD_ACTIVATE: pinCode = `SPC_ENC_ACTIVATE;
      spc_pkg::SPC_CMD_READ: pinCode = `SPC_ENC_READ;
      spc_pkg::SPC_CMD_WRITE: pinCode = `SPC_ENC_WRITE;
      spc_pkg::SPC_CMD_PRECHARGE: pinCode = `SPC_ENC_PRECHARGE;
      spc_pkg::SPC_CMD_REFRESH: pinCode = `SPC_ENC_REFRESH;
      spc_pkg::SPC_CMD_MODE_SET: pinCode = `SPC_ENC_MODE;
      spc_pkg::SPC_CMD_BURST_STOP: pinCode = `SPC_ENC_BURST_STOP;
      spc_pkg::SPC_CMD_SELF_ENTER: begin
        // Refresh code with the clock enable dropping
        pinCode = `SPC_ENC_REFRESH;
        ckeTouch = 1'h1;
        ckeValue = 1'h0;
      end
      spc_pkg::SPC_CMD_SUSPEND_ENTER: begin
        ckeTouch = 1'h1;
        ckeValue = 1'h0;
      end
      spc_pkg::SPC_CMD_SELF_EXIT, spc_pkg::SPC_CMD_SUSPEND_EXIT: begin
        ckeTouch = 1'h1;
        ckeValue = 1'h1;
      end
      default: pinCode = `SPC_ENC_NOP;
    endcase
  end

endmodule

// ==== verilog/spc_host_arb.sv ====
/*
  Host handover sequencer: on a host request it puts the SDRAM in
  self-refresh, floats the pins, grants, and wakes the SDRAM on release.
  Assumes hostReq is active high and synchronous to clk.
*/
module spc_host_arb (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hostReq,
  input wire logic busOwner,
  input wire logic cmdTake,
  output spc_pkg::spc_arb_state_t state,
  output spc_pkg::spc_arb_state_t stateNext
);

  spc_pkg::spc_arb_state_t state_reg;
  spc_pkg::spc_arb_state_t state_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spc_pkg::SPC_ARB_IDLE: begin
        // A command taken this cycle finishes before the handover starts
        if (hostReq && busOwner && !cmdTake) begin
          state_next = spc_pkg::SPC_ARB_SELF;
        end
      end
      spc_pkg::SPC_ARB_SELF: state_next = spc_pkg::SPC_ARB_FLOAT;
      spc_pkg::SPC_ARB_FLOAT: state_next = spc_pkg::SPC_ARB_GRANT;
      spc_pkg::SPC_ARB_GRANT: begin
        if (!hostReq) begin
          state_next = spc_pkg::SPC_ARB_WAKE;
        end
      end
      spc_pkg::SPC_ARB_WAKE: state_next = spc_pkg::SPC_ARB_IDLE;
      default: state_next = spc_pkg::SPC_ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= spc_pkg::SPC_ARB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;
  assign stateNext = state_next;

endmodule

// ==== dv/spc_sdram_model.sv ====
/*
  Behavioural SDRAM seen from its pins: tracks self-refresh and which
  data half it floats under the masks.
  Assumes the bench resolves released pins to their pull levels.
*/
`include "spc_cfg.svh"

module spc_sdram_model (
  input wire logic clk,
  input wire logic selectN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic lowMaskIn,
  input wire logic highMaskIn,
  input wire logic cke,
  output logic selfRefresh,
  output logic lowHalfFloat,
  output logic highHalfFloat
);
  timeunit 1ns;
  timeprecision 100ps;

  logic ckeLast;

  initial begin
    ckeLast = 1'h1;
    selfRefresh = 1'h0;
    lowHalfFloat = 1'h0;
    highHalfFloat = 1'h0;
  end

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  // Entry needs the refresh code with clock enable falling in the same cycle
  always @(posedge clk) begin
    ckeLast <= cke;
    if (!selectN && ckeLast && !cke && {rasN, casN, weN} === `SPC_ENC_REFRESH) begin
      selfRefresh <= 1'h1;
    end else if (selfRefresh && cke) begin
      selfRefresh <= 1'h0;
    end
    lowHalfFloat <= lowMaskIn;
    highHalfFloat <= highMaskIn;
  end
endmodule

// ==== dv/spc_pin_control_tb.sv ====
/*
  Self-checking bench of the SDRAM pin control block with an SDRAM model.
  Assumes the design package and spc_cfg.svh are compiled and on the path.
*/
`include "spc_cfg.svh"

`define SPC_CHK(got, exp) begin \
  nChecks++; \
  if ((got) !== (exp)) begin \
    errCount++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

module spc_pin_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_n, cmdValid, cmdA10, cmdSingleWord, bus32Mode, busOwner, hostBusRequestN;
  spc_pkg::spc_cmd_t cmdKind;
  logic [31:0] cmdAddr;
  logic cmdReady, sdramSpaceSelectN, sdramSpaceSelectOe, rowStrobeN, colStrobeN;
  logic sdramWriteEnableN, lowWordDataMask, highWordDataMask, sdramAddrBitTen;
  logic sdramClockEnable, sdramCtrlOe, hostBusGrantN, hostBusGrantOe;
  logic selfRefresh, lowHalfFloat, highHalfFloat;
  int errCount = 0;
  int nChecks = 0;
  int cycles = 0;

  // ----------------------------------------
  // Wire levels: released pins fall to pull-ups, clock enable to its pull-down
  // ----------------------------------------
  wire logic selW = sdramSpaceSelectOe ? sdramSpaceSelectN : 1'h1;
  wire logic rasW = sdramCtrlOe ? rowStrobeN : 1'h1;
  wire logic casW = sdramCtrlOe ? colStrobeN : 1'h1;
  wire logic weW = sdramCtrlOe ? sdramWriteEnableN : 1'h1;
  wire logic lowMaskW = sdramCtrlOe ? lowWordDataMask : 1'h1;
  wire logic highMaskW = sdramCtrlOe ? highWordDataMask : 1'h1;
  wire logic ckeW = sdramCtrlOe ? sdramClockEnable : 1'h0;
  wire logic [2:0] pinCode = {rowStrobeN, colStrobeN, sdramWriteEnableN};

  spc_pin_control spc_pin_control_i (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdA10(cmdA10), .cmdSingleWord(cmdSingleWord),
    .bus32Mode(bus32Mode), .busOwner(busOwner), .hostBusRequestN(hostBusRequestN),
    .sdramSpaceSelectN(sdramSpaceSelectN), .sdramSpaceSelectOe(sdramSpaceSelectOe),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .sdramWriteEnableN(sdramWriteEnableN), .lowWordDataMask(lowWordDataMask),
    .highWordDataMask(highWordDataMask), .sdramAddrBitTen(sdramAddrBitTen),
    .sdramClockEnable(sdramClockEnable), .sdramCtrlOe(sdramCtrlOe),
    .hostBusGrantN(hostBusGrantN), .hostBusGrantOe(hostBusGrantOe)
  );

  spc_sdram_model spc_sdram_model_i (
    .clk(clk), .selectN(selW), .rasN(rasW), .casN(casW), .weN(weW), .lowMaskIn(lowMaskW),
    .highMaskIn(highMaskW), .cke(ckeW), .selfRefresh(selfRefresh), .lowHalfFloat(lowHalfFloat),
    .highHalfFloat(highHalfFloat)
  );

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic testDone();
    if (errCount == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Holds the request until an edge samples ready high, then leaves the bench
  // at the falling edge of the cycle that shows the command
  task automatic issue(input spc_pkg::spc_cmd_t k, input logic [31:0] a, input logic t,
                       input logic sw, input logic b32);
    @(posedge clk);
    cmdValid <= 1'h1;
    cmdKind <= k;
    cmdAddr <= a;
    cmdA10 <= t;
    cmdSingleWord <= sw;
    bus32Mode <= b32;
    @(posedge clk);
    while (!cmdReady) begin
      @(posedge clk);
    end
    cmdValid <= 1'h0;
    @(negedge clk);
  endtask

  task automatic rw(input spc_pkg::spc_cmd_t k, input logic [31:0] a, input logic sw,
                    input logic b32, input logic [2:0] code, input logic lo, input logic hi);
    issue(k, a, 1'h0, sw, b32);
    `SPC_CHK(pinCode, code)
    `SPC_CHK(sdramSpaceSelectN, 1'h0)
    `SPC_CHK(sdramSpaceSelectOe, 1'h1)
    `SPC_CHK(lowWordDataMask, lo)
    `SPC_CHK(highWordDataMask, hi)
    @(negedge clk);
    `SPC_CHK({pinCode, lowWordDataMask, highWordDataMask}, 5'h1C)
    `SPC_CHK({lowHalfFloat, highHalfFloat}, {lo, hi})
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (11) @(posedge clk);
    @(negedge clk);
    `SPC_CHK({cmdReady, sdramSpaceSelectN, pinCode}, 5'h0F)
    `SPC_CHK({lowWordDataMask, highWordDataMask, sdramAddrBitTen}, 3'h0)
    `SPC_CHK({sdramClockEnable, sdramCtrlOe, hostBusGrantN}, 3'h5)
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    `SPC_CHK(cmdReady, 1'h1)
  endtask

  task automatic t_rw();
    rw(spc_pkg::SPC_CMD_WRITE, 32'h04000001, 1'h1, 1'h0, `SPC_ENC_WRITE, 1'h1, 1'h0);
    rw(spc_pkg::SPC_CMD_WRITE, 32'h04000002, 1'h1, 1'h0, `SPC_ENC_WRITE, 1'h0, 1'h1);
    rw(spc_pkg::SPC_CMD_WRITE, 32'h04000003, 1'h1, 1'h1, `SPC_ENC_WRITE, 1'h0, 1'h1);
    rw(spc_pkg::SPC_CMD_WRITE, 32'h07FFFFF1, 1'h0, 1'h0, `SPC_ENC_WRITE, 1'h0, 1'h0);
    rw(spc_pkg::SPC_CMD_READ, 32'h04000001, 1'h1, 1'h0, `SPC_ENC_READ, 1'h0, 1'h0);
    rw(spc_pkg::SPC_CMD_READ, 32'h04000002, 1'h1, 1'h1, `SPC_ENC_READ, 1'h0, 1'h0);
  endtask

  task automatic t_other();
    spc_pkg::spc_cmd_t kinds [5] = '{spc_pkg::SPC_CMD_ACTIVATE, spc_pkg::SPC_CMD_PRECHARGE,
      spc_pkg::SPC_CMD_REFRESH, spc_pkg::SPC_CMD_MODE_SET, spc_pkg::SPC_CMD_BURST_STOP};
    logic [2:0] codes [5] = '{`SPC_ENC_ACTIVATE, `SPC_ENC_PRECHARGE, `SPC_ENC_REFRESH,
      `SPC_ENC_MODE, `SPC_ENC_BURST_STOP};
    for (int i = 0; i < 5; i++) begin
      issue(kinds[i], 32'h04000400, i[0], 1'h0, 1'h0);
      `SPC_CHK(pinCode, codes[i])
      `SPC_CHK(sdramSpaceSelectN, 1'h0)
      `SPC_CHK(sdramAddrBitTen, i[0])
    end
  endtask

  task automatic t_space();
    issue(spc_pkg::SPC_CMD_REFRESH, 32'h08000000, 1'h1, 1'h0, 1'h0);
    `SPC_CHK({sdramSpaceSelectN, pinCode, sdramAddrBitTen}, 5'h03)
    @(negedge clk);
    `SPC_CHK({pinCode, sdramAddrBitTen}, 4'hF)
    issue(spc_pkg::SPC_CMD_READ, 32'h08000001, 1'h1, 1'h1, 1'h0);
    `SPC_CHK({sdramSpaceSelectN, pinCode}, 4'hF)
    issue(spc_pkg::SPC_CMD_ACTIVATE, 32'h00000000, 1'h1, 1'h1, 1'h0);
    `SPC_CHK({sdramSpaceSelectN, pinCode}, 4'hF)
  endtask

  task automatic t_cke();
    issue(spc_pkg::SPC_CMD_SELF_ENTER, 32'h04000000, 1'h0, 1'h0, 1'h0);
    `SPC_CHK({sdramSpaceSelectN, pinCode, sdramClockEnable}, 5'h2)
    @(negedge clk);
    `SPC_CHK({selfRefresh, sdramClockEnable}, 2'h2)
    issue(spc_pkg::SPC_CMD_SELF_EXIT, 32'h04000000, 1'h0, 1'h0, 1'h0);
    `SPC_CHK(sdramClockEnable, 1'h1)
    issue(spc_pkg::SPC_CMD_SUSPEND_ENTER, 32'h04000000, 1'h0, 1'h0, 1'h0);
    @(negedge clk);
    `SPC_CHK(sdramClockEnable, 1'h0)
    issue(spc_pkg::SPC_CMD_SUSPEND_EXIT, 32'h04000000, 1'h0, 1'h0, 1'h0);
    `SPC_CHK(sdramClockEnable, 1'h1)
  endtask

  task automatic t_host();
    @(posedge clk);
    hostBusRequestN <= 1'h0;
    @(posedge clk);
    @(negedge clk);
    `SPC_CHK(cmdReady, 1'h0)
    @(negedge clk);
    `SPC_CHK({cmdReady, sdramSpaceSelectN, pinCode, sdramClockEnable}, 6'h02)
    @(negedge clk);
    `SPC_CHK({sdramCtrlOe, sdramSpaceSelectOe, hostBusGrantN}, 3'h1)
    @(negedge clk);
    `SPC_CHK({hostBusGrantN, hostBusGrantOe, selfRefresh}, 3'h3)
    repeat (6) begin
      @(negedge clk);
      `SPC_CHK({hostBusGrantN, cmdReady}, 2'h0)
    end
    @(posedge clk);
    hostBusRequestN <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    `SPC_CHK({hostBusGrantN, sdramCtrlOe, sdramClockEnable}, 3'h4)
    @(negedge clk);
    `SPC_CHK({hostBusGrantN, sdramCtrlOe, sdramClockEnable, pinCode}, 6'h3F)
    @(negedge clk);
    `SPC_CHK({cmdReady, selfRefresh}, 2'h2)
  endtask

  task automatic t_nonowner();
    @(posedge clk);
    busOwner <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `SPC_CHK({sdramSpaceSelectOe, cmdReady, hostBusGrantOe}, 3'h0)
    @(posedge clk);
    hostBusRequestN <= 1'h0;
    repeat (4) @(negedge clk);
    `SPC_CHK({hostBusGrantN, sdramClockEnable}, 2'h3)
    @(posedge clk);
    hostBusRequestN <= 1'h1;
    @(posedge clk);
    busOwner <= 1'h1;
    repeat (3) @(posedge clk);
    rw(spc_pkg::SPC_CMD_READ, 32'h04000005, 1'h1, 1'h0, `SPC_ENC_READ, 1'h0, 1'h0);
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      testDone();
    end
  end

  initial begin
    rst_n = 1'h0;
    cmdValid = 1'h0;
    cmdKind = spc_pkg::SPC_CMD_NOP;
    cmdAddr = 32'h00000000;
    cmdA10 = 1'h0;
    cmdSingleWord = 1'h0;
    bus32Mode = 1'h0;
    busOwner = 1'h1;
    hostBusRequestN = 1'h1;
    t_reset();
    t_rw();
    t_other();
    t_space();
    t_cke();
    t_host();
    t_nonowner();
    testDone();
  end
endmodule
